/* rtl/mlsc_defs.svh */
// register map, field positions and reset values of the modem status block
`ifndef MLSC_DEFS_SVH
`define MLSC_DEFS_SVH

`define MLSC_ADDR_W      6
`define MLSC_IDX_W       4
`define MLSC_IDX_LSB     2
`define MLSC_IDX_CTRL    4'h4
`define MLSC_IDX_STAT    4'h6
`define MLSC_IDX_IST     4'h8
`define MLSC_IDX_IMSK    4'h9
`define MLSC_CTL_DTR     0
`define MLSC_CTL_RTS     1
`define MLSC_CTL_GEN1    2
`define MLSC_CTL_GEN2    3
`define MLSC_CTL_LOOP    4
`define MLSC_CTL_W       5
`define MLSC_CTL_RST     5'h00
`define MLSC_LN_CTS      0
`define MLSC_LN_DSR      1
`define MLSC_LN_RI       2
`define MLSC_LN_DCD      3
`define MLSC_EV_CHG      0
`define MLSC_EV_RING     1
`define MLSC_EV_W        2
`define MLSC_EV_RST      2'h0
`define MLSC_RESP_OKAY   2'h0
`define MLSC_RESP_SLVERR 2'h2

`endif

/* rtl/mlsc_pkg.sv */
// shared types of the modem status block
package mlsc_pkg;
	typedef enum logic {
		MLSC_RD_IDLE = 1'b0,
		MLSC_RD_DATA = 1'b1
	} mlsc_rd_state_t;
	typedef logic [3:0] mlsc_lines_t;
endpackage

/* rtl/mlsc_reg_if.sv */
// register access strobes between bus slave and register bank
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_defs.svh"
interface mlsc_reg_if;
	logic                   wr_en;
	logic [`MLSC_IDX_W-1:0] wr_idx;
	logic [7:0]             wr_data;
	logic                   wr_err;
	logic                   rd_en;
	logic [`MLSC_IDX_W-1:0] rd_idx;
	logic [7:0]             rd_data;
	logic                   rd_err;
	modport bus (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
		input wr_err, rd_data, rd_err);
	modport bank (input wr_en, wr_idx, wr_data, rd_en, rd_idx,
		output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

/* rtl/mlsc_axil.sv */
// AXI4-Lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_defs.svh"
module mlsc_axil (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [`MLSC_ADDR_W-1:0] awaddr,
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output logic                         wready,
	output logic [1:0]                   bresp,
	output logic                         bvalid,
	input  wire logic                    bready,
	input  wire logic [`MLSC_ADDR_W-1:0] araddr,
	input  wire logic                    arvalid,
	output logic                         arready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	output logic                         rvalid,
	input  wire logic                    rready,
	mlsc_reg_if.bus                      rg
);
	logic                   aw_q, aw_d, w_q, w_d, bv_q, bv_d;
	logic [`MLSC_IDX_W-1:0] awi_q, awi_d;
	logic [7:0]             wd_q, wd_d;
	logic                   ws_q, ws_d;
	logic [1:0]             br_q, br_d, rr_q, rr_d;
	logic [7:0]             rd_q, rd_d;
	logic                   do_wr;
	mlsc_pkg::mlsc_rd_state_t rs_q, rs_d;

	assign awready = !aw_q && !bv_q;
	assign wready  = !w_q && !bv_q;
	assign do_wr   = aw_q && w_q && !bv_q;
	assign arready = (rs_q == mlsc_pkg::MLSC_RD_IDLE);
	assign bvalid  = bv_q;
	assign bresp   = br_q;
	assign rvalid  = (rs_q == mlsc_pkg::MLSC_RD_DATA);
	assign rresp   = rr_q;
	assign rdata   = {24'h000000, rd_q};
	assign rg.wr_en   = do_wr && ws_q;
	assign rg.wr_idx  = awi_q;
	assign rg.wr_data = wd_q;
	assign rg.rd_en   = arvalid && arready;
	assign rg.rd_idx  = araddr[`MLSC_ADDR_W-1:`MLSC_IDX_LSB];

	always_comb begin
		aw_d  = aw_q;
		awi_d = awi_q;
		w_d   = w_q;
		wd_d  = wd_q;
		ws_d  = ws_q;
		bv_d  = bv_q;
		br_d  = br_q;
		// address and data are taken in either order
		if (awvalid && awready) begin
			aw_d  = 1'b1;
			awi_d = awaddr[`MLSC_ADDR_W-1:`MLSC_IDX_LSB];
		end
		if (wvalid && wready) begin
			w_d  = 1'b1;
			wd_d = wdata[7:0];
			ws_d = wstrb[0];
		end
		if (do_wr) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			bv_d = 1'b1;
			br_d = rg.wr_err ? `MLSC_RESP_SLVERR : `MLSC_RESP_OKAY;
		end else if (bv_q && bready) begin
			bv_d = 1'b0;
		end
	end

	always_comb begin
		rs_d = rs_q;
		rd_d = rd_q;
		rr_d = rr_q;
		case (rs_q)
			mlsc_pkg::MLSC_RD_IDLE: begin
				if (arvalid) begin
					rs_d = mlsc_pkg::MLSC_RD_DATA;
					rd_d = rg.rd_data;
					rr_d = rg.rd_err ? `MLSC_RESP_SLVERR : `MLSC_RESP_OKAY;
				end
			end
			mlsc_pkg::MLSC_RD_DATA: begin
				if (rready)
					rs_d = mlsc_pkg::MLSC_RD_IDLE;
			end
			default: rs_d = mlsc_pkg::MLSC_RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q  <= 1'b0;
			awi_q <= '0;
			w_q   <= 1'b0;
			wd_q  <= 8'h00;
			ws_q  <= 1'b0;
			bv_q  <= 1'b0;
			br_q  <= `MLSC_RESP_OKAY;
			rs_q  <= mlsc_pkg::MLSC_RD_IDLE;
			rd_q  <= 8'h00;
			rr_q  <= `MLSC_RESP_OKAY;
		end else begin
			aw_q  <= aw_d;
			awi_q <= awi_d;
			w_q   <= w_d;
			wd_q  <= wd_d;
			ws_q  <= ws_d;
			bv_q  <= bv_d;
			br_q  <= br_d;
			rs_q  <= rs_d;
			rd_q  <= rd_d;
			rr_q  <= rr_d;
		end
	end

	property p_bvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold)
		else $error("write response dropped before bready");

	property p_rvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold)
		else $error("read data changed before rready");
endmodule
`default_nettype wire

/* rtl/mlsc_top.sv */
// modem line status capture with control, interrupt and AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_defs.svh"
module mlsc_top (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [`MLSC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`MLSC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    carrier_detect_n,
	input  wire logic                    ring_indicator_n,
	input  wire logic                    set_ready_n,
	input  wire logic                    clear_to_send_n,
	output logic                         terminal_ready_n,
	output logic                         request_to_send_n,
	output logic                         general_output_one_n,
	output logic                         general_output_two_n,
	output logic                         modem_status_irq,
	output logic                         irq
);
	mlsc_reg_if rg ();

	logic [`MLSC_CTL_W-1:0] ctrl_q, ctrl_d;
	logic [`MLSC_EV_W-1:0]  ist_q, ist_d, imsk_q, imsk_d, ev;
	mlsc_pkg::mlsc_lines_t  lvl, prev_q, prev_d, chg;
	mlsc_pkg::mlsc_lines_t  delta_q, delta_d;
	logic                   seen_q;
	logic                   loop;
	logic                   stat_rd;
	logic [7:0]             modem_line_status;

	// one decode serves both the read and the write path
	function automatic logic idx_mapped(input logic [`MLSC_IDX_W-1:0] i);
		idx_mapped = (i == `MLSC_IDX_CTRL) || (i == `MLSC_IDX_STAT) ||
			(i == `MLSC_IDX_IST) || (i == `MLSC_IDX_IMSK);
	endfunction

	mlsc_axil u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.rg      (rg)
	);

	assign loop = ctrl_q[`MLSC_CTL_LOOP];

	// complement of the pins when not looped
	always_comb begin
		if (loop) begin
			lvl[`MLSC_LN_DCD] = ctrl_q[`MLSC_CTL_GEN2];
			lvl[`MLSC_LN_RI]  = ctrl_q[`MLSC_CTL_GEN1];
			lvl[`MLSC_LN_DSR] = ctrl_q[`MLSC_CTL_DTR];
			lvl[`MLSC_LN_CTS] = ctrl_q[`MLSC_CTL_RTS];
		end else begin
			lvl[`MLSC_LN_DCD] = !carrier_detect_n;
			lvl[`MLSC_LN_RI]  = !ring_indicator_n;
			lvl[`MLSC_LN_DSR] = !set_ready_n;
			lvl[`MLSC_LN_CTS] = !clear_to_send_n;
		end
	end

	// outputs idle high in loopback so the far end sees no activity
	assign terminal_ready_n     = loop | !ctrl_q[`MLSC_CTL_DTR];
	assign request_to_send_n    = loop | !ctrl_q[`MLSC_CTL_RTS];
	assign general_output_one_n = loop | !ctrl_q[`MLSC_CTL_GEN1];
	assign general_output_two_n = loop | !ctrl_q[`MLSC_CTL_GEN2];

	assign modem_line_status = {lvl, delta_q};
	assign stat_rd = rg.rd_en && (rg.rd_idx == `MLSC_IDX_STAT);

	// no change is flagged until one sample has been taken after reset
	always_comb begin
		prev_d = lvl;
		chg[`MLSC_LN_DCD] = seen_q &&
			(lvl[`MLSC_LN_DCD] != prev_q[`MLSC_LN_DCD]);
		// ring pin low to high, inverted level falls
		chg[`MLSC_LN_RI]  = seen_q &&
			prev_q[`MLSC_LN_RI] && !lvl[`MLSC_LN_RI];
		chg[`MLSC_LN_DSR] = seen_q &&
			(lvl[`MLSC_LN_DSR] != prev_q[`MLSC_LN_DSR]);
		// clear to send changed either way
		chg[`MLSC_LN_CTS] = seen_q &&
			(lvl[`MLSC_LN_CTS] != prev_q[`MLSC_LN_CTS]);
		// read clears, a change in that cycle still sets
		delta_d = (stat_rd ? 4'h0 : delta_q) | chg;
	end

	// level request while any flag is set
	// falls with the last flag cleared
	assign modem_status_irq = |delta_q;

	assign ev[`MLSC_EV_CHG]  = |chg;
	assign ev[`MLSC_EV_RING] = chg[`MLSC_LN_RI];
	assign irq = |(ist_q & imsk_q);

	always_comb begin
		ctrl_d = ctrl_q;
		imsk_d = imsk_q;
		ist_d  = ist_q;
		// no write path into the status register
		if (rg.wr_en) begin
			case (rg.wr_idx)
				`MLSC_IDX_CTRL: ctrl_d = rg.wr_data[`MLSC_CTL_W-1:0];
				`MLSC_IDX_IMSK: imsk_d = rg.wr_data[`MLSC_EV_W-1:0];
				`MLSC_IDX_IST:  ist_d  = ist_q &
					~rg.wr_data[`MLSC_EV_W-1:0];
				default: ;
			endcase
		end
		// new events win over a same-cycle clear
		ist_d = ist_d | ev;
	end

	always_comb begin
		rg.rd_data = 8'h00;
		case (rg.rd_idx)
			`MLSC_IDX_CTRL: rg.rd_data[`MLSC_CTL_W-1:0] = ctrl_q;
			`MLSC_IDX_STAT: rg.rd_data = modem_line_status;
			`MLSC_IDX_IST:  rg.rd_data[`MLSC_EV_W-1:0] = ist_q;
			`MLSC_IDX_IMSK: rg.rd_data[`MLSC_EV_W-1:0] = imsk_q;
			default: rg.rd_data = 8'h00;
		endcase
		rg.rd_err = !idx_mapped(rg.rd_idx);
		rg.wr_err = !idx_mapped(rg.wr_idx) || (rg.wr_idx == `MLSC_IDX_STAT);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= `MLSC_CTL_RST;
			imsk_q  <= `MLSC_EV_RST;
			ist_q   <= `MLSC_EV_RST;
			prev_q  <= 4'h0;
			delta_q <= 4'h0;
			seen_q  <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			imsk_q  <= imsk_d;
			ist_q   <= ist_d;
			prev_q  <= prev_d;
			delta_q <= delta_d;
			seen_q  <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_stat_read_quiet;
		stat_rd && (chg == 4'h0);
	endsequence

	property p_dcd_pin;
		!loop |-> modem_line_status[7] == !carrier_detect_n;
	endproperty
	a_dcd_pin: assert property (p_dcd_pin)
		else $error("bit 7 does not mirror carrier detect");

	property p_dcd_loop;
		loop |-> modem_line_status[7] == ctrl_q[`MLSC_CTL_GEN2];
	endproperty
	a_dcd_loop: assert property (p_dcd_loop)
		else $error("bit 7 does not follow output two in loopback");

	property p_ri_bit;
		modem_line_status[6] ==
			(loop ? ctrl_q[`MLSC_CTL_GEN1] : !ring_indicator_n);
	endproperty
	a_ri_bit: assert property (p_ri_bit)
		else $error("bit 6 wrong");

	property p_dsr_bit;
		modem_line_status[5] ==
			(loop ? ctrl_q[`MLSC_CTL_DTR] : !set_ready_n);
	endproperty
	a_dsr_bit: assert property (p_dsr_bit)
		else $error("bit 5 wrong");

	property p_cts_bit;
		modem_line_status[4] ==
			(loop ? ctrl_q[`MLSC_CTL_RTS] : !clear_to_send_n);
	endproperty
	a_cts_bit: assert property (p_cts_bit)
		else $error("bit 4 wrong");

	property p_dcd_change;
		seen_q && !loop && $stable(loop) && $changed(carrier_detect_n)
			|=> delta_q[`MLSC_LN_DCD];
	endproperty
	a_dcd_change: assert property (p_dcd_change)
		else $error("carrier detect change not flagged");

	property p_ri_rise_only;
		$rose(delta_q[`MLSC_LN_RI]) |->
			$past(prev_q[`MLSC_LN_RI]) && !$past(lvl[`MLSC_LN_RI]);
	endproperty
	a_ri_rise_only: assert property (p_ri_rise_only)
		else $error("ring flag set without a low to high pin edge");

	property p_dsr_change;
		seen_q && !loop && $stable(loop) && $changed(set_ready_n)
			|=> delta_q[`MLSC_LN_DSR];
	endproperty
	a_dsr_change: assert property (p_dsr_change)
		else $error("set ready change not flagged");

	property p_cts_change;
		seen_q && !loop && $stable(loop) && $changed(clear_to_send_n)
			|=> delta_q[`MLSC_LN_CTS];
	endproperty
	a_cts_change: assert property (p_cts_change)
		else $error("clear to send change not flagged");

	property p_read_clears;
		s_stat_read_quiet |=> delta_q == 4'h0;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("status read did not clear change flags");

	property p_irq_level;
		modem_status_irq == (modem_line_status[3:0] != 4'h0);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("modem interrupt missing while a flag is set");

	property p_read_only;
		rg.wr_en && (rg.wr_idx == `MLSC_IDX_STAT) && !stat_rd &&
			(chg == 4'h0) |=> $stable(delta_q);
	endproperty
	a_read_only: assert property (p_read_only)
		else $error("write altered the status register");

	property p_irq_drop;
		s_stat_read_quiet ##1 (chg == 4'h0) |=> !modem_status_irq [*1];
	endproperty
	a_irq_drop: assert property (p_irq_drop)
		else $error("modem interrupt held after flags cleared");

	property p_ri_release;
		seen_q && !loop && $stable(loop) && $rose(ring_indicator_n)
			|=> delta_q[`MLSC_LN_RI];
	endproperty
	a_ri_release: assert property (p_ri_release)
		else $error("ring pin release not flagged");

	property p_ri_assert_quiet;
		!loop && $stable(loop) && $fell(ring_indicator_n) &&
			!delta_q[`MLSC_LN_RI] |=> !delta_q[`MLSC_LN_RI];
	endproperty
	a_ri_assert_quiet: assert property (p_ri_assert_quiet)
		else $error("ring flag set on pin going low");

	property p_stat_decode;
		stat_rd |-> rg.rd_data == modem_line_status && !rg.rd_err;
	endproperty
	a_stat_decode: assert property (p_stat_decode)
		else $error("status register not readable at its index");
endmodule
`default_nettype wire

/* tb/mlsc_modem.sv */
// modem side model: drives the four handshake lines, active low
`timescale 1ns/1ps
`default_nettype none
module mlsc_modem (
	input  wire logic       aclk,
	input  wire logic [3:0] assert_lines,
	output logic            carrier_detect_n,
	output logic            ring_indicator_n,
	output logic            set_ready_n,
	output logic            clear_to_send_n
);
	// single driver; reset outlasts the unknown first cycle
	always @(posedge aclk) begin
		{carrier_detect_n, ring_indicator_n} <= ~assert_lines[3:2];
		{set_ready_n, clear_to_send_n} <= ~assert_lines[1:0];
	end
endmodule
`default_nettype wire

/* tb/modem_line_status_capture_tb.sv */
// self-checking bench of the modem line status capture block
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_defs.svh"
module modem_line_status_capture_tb;
	logic        aclk, aresetn;
	logic [5:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, lines, lv, flg;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r, ist, msk;
	logic        dcd_n, ri_n, dsr_n, cts_n;
	logic        dtr_n, rts_n, o1_n, o2_n, msi, irq;
	logic [4:0]  ctl;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;

	mlsc_modem modem (.aclk(aclk), .assert_lines(lines),
		.carrier_detect_n(dcd_n), .ring_indicator_n(ri_n),
		.set_ready_n(dsr_n), .clear_to_send_n(cts_n));
	mlsc_top dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .carrier_detect_n(dcd_n),
		.ring_indicator_n(ri_n), .set_ready_n(dsr_n),
		.clear_to_send_n(cts_n), .terminal_ready_n(dtr_n),
		.request_to_send_n(rts_n), .general_output_one_n(o1_n),
		.general_output_two_n(o2_n), .modem_status_irq(msi),
		.irq(irq));

	initial begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end
	// whole run is a few hundred cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		logic aw, w;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		aw = 1;
		w = 1;
		forever begin
			@(posedge aclk);
			if (aw && awready) begin
				awvalid <= 0;
				aw = 0;
			end
			if (w && wready) begin
				wvalid <= 0;
				w = 0;
			end
			if (bvalid) begin
				rs = bresp;
				bready <= 0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		logic pend;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		pend = 1;
		forever begin
			@(posedge aclk);
			if (pend && arready) begin
				arvalid <= 0;
				pend = 0;
			end
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				rready <= 0;
				break;
			end
		end
	endtask

	// loopback source order: out two, out one, dtr, rts
	function automatic logic [3:0] eff();
		return ctl[`MLSC_CTL_LOOP] ? {ctl[3], ctl[2], ctl[0], ctl[1]} : lv;
	endfunction

	task automatic settle(input logic [3:0] old);
		logic [3:0] nw, ev;
		nw = eff();
		ev = (old ^ nw) & 4'hB;
		// ring flag only when the pin is released
		ev[2] = old[2] & ~nw[2];
		flg |= ev;
		ist |= {ev[2], |ev};
		repeat (4) @(posedge aclk);
		chk("msi", {31'h0, msi}, {31'h0, |flg});
		chk("irq", {31'h0, irq}, {31'h0, |(ist & msk)});
	endtask

	task automatic set_lines(input logic [3:0] v);
		logic [3:0] old;
		old = eff();
		@(posedge aclk);
		lines <= v;
		lv = v;
		settle(old);
	endtask

	task automatic set_ctl(input logic [4:0] v);
		logic [3:0] old;
		old = eff();
		wr(6'h10, {27'h0, v}, r);
		ctl = v;
		settle(old);
		chk("mout", {28'h0, o2_n, o1_n, rts_n, dtr_n},
			{28'h0, v[4] ? 4'hF : ~v[3:0]});
	endtask

	task automatic rd_status();
		rd(6'h18, d, r);
		chk("status", d, {24'h0, eff(), flg});
		chk("rresp", {30'h0, r}, 32'h0);
		flg = 4'h0;
		chk("msi_clr", {31'h0, msi}, 32'h0);
	endtask

	initial begin
		aresetn = 0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{lines, lv, flg, ctl, ist, msk} = '0;
		void'($urandom(32'h634dedd8));
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		wstrb <= 4'hF;
		repeat (2) @(posedge aclk);
		chk("mout0", {28'h0, o2_n, o1_n, rts_n, dtr_n}, 32'hF);
		chk("irq0", {31'h0, irq}, 32'h0);
		rd_status();
		repeat (24) begin
			set_lines(4'($urandom));
			rd_status();
		end
		// ring asserted then released
		set_lines(4'h4);
		rd_status();
		set_lines(4'h0);
		set_lines(4'h1);
		rd_status();
		wr(6'h18, 32'hFF, r);
		chk("wr_ro", {30'h0, r}, {30'h0, `MLSC_RESP_SLVERR});
		set_lines(4'hF);
		rd_status();
		rd(6'h3C, d, r);
		chk("unmap", {d[29:0], r}, {30'h0, `MLSC_RESP_SLVERR});
		repeat (8) begin
			set_ctl({1'b1, 4'($urandom)});
			rd_status();
			set_lines(~lv);
			rd_status();
		end
		rd(6'h10, d, r);
		chk("ctl", d, {27'h0, ctl});
		// lane 0 strobe low: accepted, no effect
		wstrb <= 4'h0;
		wr(6'h10, 32'h1F, r);
		wstrb <= 4'hF;
		chk("wr_nostrb", {30'h0, r}, 32'h0);
		rd(6'h10, d, r);
		chk("ctl_keep", d, {27'h0, ctl});
		wr(6'h3C, 32'h1, r);
		chk("wr_unmap", {30'h0, r}, {30'h0, `MLSC_RESP_SLVERR});
		set_ctl({1'b0, 4'($urandom)});
		rd_status();
		wr(6'h20, 32'h3, r);
		ist = 2'h0;
		wr(6'h24, 32'h3, r);
		msk = 2'h3;
		set_lines(lv ^ 4'h1);
		rd(6'h20, d, r);
		chk("ist", d, {30'h0, ist});
		wr(6'h24, 32'h0, r);
		msk = 2'h0;
		chk("irq_msk", {31'h0, irq}, 32'h0);
		wr(6'h24, 32'h1, r);
		msk = 2'h1;
		chk("irq_on", {31'h0, irq}, 32'h1);
		wr(6'h20, 32'h1, r);
		ist = 2'h0;
		chk("irq_clr", {31'h0, irq}, 32'h0);
		rd_status();
		// reset in mid-run clears control, flags and interrupts
		@(posedge aclk);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		{flg, ctl, ist, msk} = '0;
		repeat (2) @(posedge aclk);
		chk("rst", {27'h0, msi, irq, o2_n, o1_n, dtr_n}, 32'h7);
		rd(6'h10, d, r);
		chk("ctl_rst", d, 32'h0);
		rd_status();
		stop_test();
	end
endmodule
`default_nettype wire
